// ==== design/sfe_flash_end.sv ====
/*
  Flash end of the erase link: serial frame receiver, opcode and address
  decode, self-timed page, block and sector erase with erase verify.
  Assumes the host drives sclk idle low, changes mosi on falling edges and
  keeps each sclk level for at least three system cycles.
*/
`timescale 1ns/1ps
`default_nettype none
module sfe_flash_end
  import sfe_pkg::*;
#(
  parameter int unsigned PAGE_ERASE_CYCLES = SFE_PAGE_ERASE_CYCLES,
  parameter int unsigned BLOCK_ERASE_CYCLES = SFE_BLOCK_ERASE_CYCLES,
  parameter int unsigned SECTOR_ERASE_CYCLES = SFE_SECTOR_ERASE_CYCLES
) (
  input wire logic sys_clk,
  input wire logic rst,
  sfe_link_if.flash link,
  input wire logic binary_page_mode,
  input wire logic erase_fault,
  input wire logic [10:0] query_page,
  output logic query_erased,
  output logic ready_busy,
  output logic erase_program_error_flag
);
  // ************************************************************
  // link synchronisers
  // ************************************************************
  logic sclk_s1, sclk_s2, sclk_s3;
  logic cs_s1, cs_s2, cs_s3;
  logic mosi_s1, mosi_s2;

  // stage one feeds stage two only; edges come from stages two and three
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      sclk_s1 <= 1'b0;
      sclk_s2 <= 1'b0;
      sclk_s3 <= 1'b0;
      cs_s1 <= 1'b1;
      cs_s2 <= 1'b1;
      cs_s3 <= 1'b1;
      mosi_s1 <= 1'b0;
      mosi_s2 <= 1'b0;
    end else begin
      sclk_s1 <= link.sclk;
      sclk_s2 <= sclk_s1;
      sclk_s3 <= sclk_s2;
      cs_s1 <= link.cs_n;
      cs_s2 <= cs_s1;
      cs_s3 <= cs_s2;
      mosi_s1 <= link.mosi;
      mosi_s2 <= mosi_s1;
    end
  end

  logic sclk_rise;
  logic cs_fall;
  logic cs_rise;
  assign sclk_rise = sclk_s2 & ~sclk_s3;
  assign cs_fall = cs_s3 & ~cs_s2;
  assign cs_rise = ~cs_s3 & cs_s2;

  // ************************************************************
  // frame receiver
  // ************************************************************
  logic [31:0] frame;
  logic [5:0] bit_count;

  // bit count saturates so an overlong frame never wraps back to 32
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      frame <= 32'h0000_0000;
      bit_count <= 6'h00;
    end else if (cs_fall) begin
      bit_count <= 6'h00;
    end else if (!cs_s2 && sclk_rise) begin
      frame <= {frame[30:0], mosi_s2};
      if (bit_count != 6'h3F) begin
        bit_count <= bit_count + 6'h01;
      end
    end
  end

  // ************************************************************
  // opcode and address decode
  // ************************************************************
  logic [7:0] opcode;
  logic [10:0] page_sel;
  logic [10:0] next_first;
  logic [10:0] next_last;
  logic [31:0] next_time;
  logic next_valid;

  assign opcode = frame[31:24];
  // standard mode skips nine low dummy bits, binary mode eight
  assign page_sel = binary_page_mode ? frame[SFE_BIN_PAGE_LSB +: SFE_PAGE_BITS]
                                     : frame[SFE_STD_PAGE_LSB +: SFE_PAGE_BITS];

  // page range and time for each erase kind
  always_comb begin
    next_first = page_sel;
    next_last = page_sel;
    next_time = PAGE_ERASE_CYCLES;
    next_valid = 1'b0;
    case (opcode)
      SFE_OP_PAGE_ERASE: begin
        next_valid = 1'b1;
      end
      SFE_OP_BLOCK_ERASE: begin
        next_valid = 1'b1;
        next_first = {page_sel[10:3], 3'b000};
        next_last = {page_sel[10:3], 3'b111};
        next_time = BLOCK_ERASE_CYCLES;
      end
      SFE_OP_SECTOR_ERASE: begin
        next_valid = 1'b1;
        next_time = SECTOR_ERASE_CYCLES;
        if (page_sel[10:8] != 3'b000) begin
          next_first = {page_sel[10:8], 8'h00};
          next_last = {page_sel[10:8], 8'hFF};
        end else if (!page_sel[3]) begin
          next_first = 11'h000;
          next_last = SFE_SECTOR0A_LAST;
        end else begin
          next_first = SFE_SECTOR0B_FIRST;
          next_last = SFE_SECTOR0B_LAST;
        end
      end
      default: begin
        next_valid = 1'b0;
      end
    endcase
  end

  logic start;
  // a frame counts only when chip select rises after exactly 32 bits
  assign start = cs_rise && (bit_count == SFE_FRAME_BITS_W) && next_valid && ready_busy;

  // ************************************************************
  // erase sequencer
  // ************************************************************
  typedef enum logic [1:0] {
    SFE_ST_IDLE = 2'b00,
    SFE_ST_SWEEP = 2'b01,
    SFE_ST_WAIT = 2'b10
  } sfe_state_type;

  sfe_state_type state;
  logic [10:0] cur_page;
  logic [10:0] last_page;
  logic [31:0] timer;

  // busy lasts the full erase time; pages are cleared one per cycle inside it
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      state <= SFE_ST_IDLE;
      cur_page <= 11'h000;
      last_page <= 11'h000;
      timer <= 32'h0000_0000;
    end else begin
      if (timer != 32'h0000_0000) begin
        timer <= timer - 32'h0000_0001;
      end
      case (state)
        SFE_ST_IDLE: begin
          if (start) begin
            state <= SFE_ST_SWEEP;
            cur_page <= next_first;
            last_page <= next_last;
            timer <= next_time - 32'h0000_0001;
          end
        end
        SFE_ST_SWEEP: begin
          if (cur_page == last_page) begin
            state <= SFE_ST_WAIT;
          end else begin
            cur_page <= cur_page + 11'h001;
          end
        end
        SFE_ST_WAIT: begin
          if (timer == 32'h0000_0000) begin
            state <= SFE_ST_IDLE;
          end
        end
        default: begin
          state <= SFE_ST_IDLE;
        end
      endcase
    end
  end

  // ************************************************************
  // array state, verify and status
  // ************************************************************
  // one erased flag per page stands in for the data; nothing programs here
  logic page_erased [0:SFE_PAGES-1];

  // a fault during the sweep leaves that page unerased, as a failed byte would
  always_ff @(posedge sys_clk) begin
    if (state == SFE_ST_SWEEP) begin
      page_erased[cur_page] <= ~erase_fault;
    end
  end

  // the query port is a plain registered array read
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      query_erased <= 1'b0;
    end else begin
      query_erased <= page_erased[query_page];
    end
  end

  // flag clears at the start of each erase; a failure always wins
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      erase_program_error_flag <= 1'b0;
    end else if (state == SFE_ST_SWEEP && erase_fault) begin
      erase_program_error_flag <= 1'b1;
    end else if (start) begin
      erase_program_error_flag <= 1'b0;
    end
  end

  // ready is high only while idle and drops the cycle after a start
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      ready_busy <= 1'b1;
    end else if (start) begin
      ready_busy <= 1'b0;
    end else if (state == SFE_ST_WAIT && timer == 32'h0000_0000) begin
      ready_busy <= 1'b1;
    end
  end

  assign link.ready = ready_busy;
endmodule : sfe_flash_end
`default_nettype wire

// ==== design/sfe_host_end.sv ====
/*
  Host end of the erase link: builds a 32-bit erase frame from a user
  command, clocks it out with its own divided serial clock and waits for
  the flash end to go busy and ready again.
  Assumes the flash end answers on the ready wire.
*/
`timescale 1ns/1ps
`default_nettype none
module sfe_host_end
  import sfe_pkg::*;
(
  input wire logic sys_clk,
  input wire logic rst,
  sfe_link_if.host link,
  input wire logic binary_page_mode,
  input wire logic cmd_valid,
  input wire sfe_kind_type cmd_kind,
  input wire logic [10:0] cmd_page,
  output logic cmd_ready,
  output logic cmd_done,
  output logic cmd_accepted
);
  // ************************************************************
  // ready synchroniser
  // ************************************************************
  logic ready_s1, ready_s2;

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      ready_s1 <= 1'b0;
      ready_s2 <= 1'b0;
    end else begin
      ready_s1 <= link.ready;
      ready_s2 <= ready_s1;
    end
  end

  // ************************************************************
  // frame builder
  // ************************************************************
  logic [7:0] op;
  logic [23:0] addr;

  // low page bits go out as given; the flash end ignores them where unused
  always_comb begin
    case (cmd_kind)
      SFE_KIND_PAGE: op = SFE_OP_PAGE_ERASE;
      SFE_KIND_BLOCK: op = SFE_OP_BLOCK_ERASE;
      SFE_KIND_SECTOR: op = SFE_OP_SECTOR_ERASE;
      default: op = SFE_OP_PAGE_ERASE;
    endcase
    if (binary_page_mode) begin
      addr = {5'h00, cmd_page, 8'h00};
    end else begin
      addr = {4'h0, cmd_page, 9'h000};
    end
  end

  // ************************************************************
  // link sequencer
  // ************************************************************
  typedef enum logic [2:0] {
    SFE_H_IDLE = 3'b000,
    SFE_H_SHIFT = 3'b001,
    SFE_H_HOLD = 3'b010,
    SFE_H_WAIT_BUSY = 3'b011,
    SFE_H_WAIT_READY = 3'b100
  } sfe_host_state_type;

  sfe_host_state_type state;
  logic [31:0] frame;
  logic [4:0] bit_idx;
  logic [3:0] div;
  logic [5:0] wait_cnt;
  logic tick;

  // divider runs in every state but idle, the busy and ready waits included
  assign tick = (div == SFE_SCLK_HALF - 4'h1);

  always_ff @(posedge sys_clk) begin
    if (rst || state == SFE_H_IDLE || tick) begin
      div <= 4'h0;
    end else begin
      div <= div + 4'h1;
    end
  end

  // mode 0: data changes while sclk is low, chip select rises after bit 0
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      state <= SFE_H_IDLE;
      frame <= 32'h0000_0000;
      bit_idx <= 5'h00;
      wait_cnt <= 6'h00;
      link.sclk <= 1'b0;
      link.cs_n <= 1'b1;
      link.mosi <= 1'b0;
      cmd_ready <= 1'b0;
      cmd_done <= 1'b0;
      cmd_accepted <= 1'b0;
    end else begin
      cmd_done <= 1'b0;
      case (state)
        SFE_H_IDLE: begin
          cmd_ready <= ready_s2;
          if (cmd_valid && cmd_ready && ready_s2) begin
            frame <= {op, addr};
            link.cs_n <= 1'b0;
            link.mosi <= op[7];
            bit_idx <= 5'h1F;
            cmd_ready <= 1'b0;
            state <= SFE_H_SHIFT;
          end
        end
        SFE_H_SHIFT: begin
          if (tick) begin
            link.sclk <= ~link.sclk;
            if (link.sclk) begin
              if (bit_idx == 5'h00) begin
                state <= SFE_H_HOLD;
              end else begin
                bit_idx <= bit_idx - 5'h01;
                link.mosi <= frame[bit_idx - 5'h01];
              end
            end
          end
        end
        SFE_H_HOLD: begin
          if (tick) begin
            link.cs_n <= 1'b1;
            wait_cnt <= 6'h00;
            state <= SFE_H_WAIT_BUSY;
          end
        end
        SFE_H_WAIT_BUSY: begin
          wait_cnt <= wait_cnt + 6'h01;
          if (!ready_s2) begin
            state <= SFE_H_WAIT_READY;
          end else if (wait_cnt == SFE_BUSY_WAIT) begin
            cmd_done <= 1'b1;
            cmd_accepted <= 1'b0;
            state <= SFE_H_IDLE;
          end
        end
        SFE_H_WAIT_READY: begin
          if (ready_s2) begin
            cmd_done <= 1'b1;
            cmd_accepted <= 1'b1;
            state <= SFE_H_IDLE;
          end
        end
        default: begin
          state <= SFE_H_IDLE;
        end
      endcase
    end
  end
endmodule : sfe_host_end
`default_nettype wire

// ==== design/sfe_link_if.sv ====
/*
  Link between the erase host and the flash end: serial clock, chip select,
  serial data and a ready level from the flash end.
  Assumes both ends sample every wire through their own synchronisers.
*/
`timescale 1ns/1ps
`default_nettype none
interface sfe_link_if;
  logic sclk;
  logic cs_n;
  logic mosi;
  logic ready;
  modport host (output sclk, output cs_n, output mosi, input ready);
  modport flash (input sclk, input cs_n, input mosi, output ready);
endinterface : sfe_link_if
`default_nettype wire

// ==== design/sfe_pkg.sv ====
/*
  Shared constants for the serial flash erase link: opcodes, frame layout,
  address field positions, erase times and link timing.
  Assumes a 40 MHz system clock on both ends.
*/
package sfe_pkg;
  // ************************************************************
  // opcodes and frame layout
  // ************************************************************
  localparam logic [7:0] SFE_OP_PAGE_ERASE = 8'h81;
  localparam logic [7:0] SFE_OP_BLOCK_ERASE = 8'h50;
  localparam logic [7:0] SFE_OP_SECTOR_ERASE = 8'h7C;
  localparam int unsigned SFE_FRAME_BITS = 32;
  localparam logic [5:0] SFE_FRAME_BITS_W = 6'h20;
  localparam int unsigned SFE_PAGE_BITS = 11;
  localparam int unsigned SFE_PAGES = 2048;
  // lowest page bit position inside the 24-bit address, per page-size mode
  localparam int unsigned SFE_STD_PAGE_LSB = 9;
  localparam int unsigned SFE_BIN_PAGE_LSB = 8;
  // sector 0b ends at the last page of the first 256-page region
  localparam logic [10:0] SFE_SECTOR0A_LAST = 11'h007;
  localparam logic [10:0] SFE_SECTOR0B_FIRST = 11'h008;
  localparam logic [10:0] SFE_SECTOR0B_LAST = 11'h0FF;

  // ************************************************************
  // timing
  // ************************************************************
  localparam int unsigned SFE_CLK_MHZ = 40;
  localparam int unsigned SFE_PAGE_ERASE_TIME_US = 20000;
  localparam int unsigned SFE_BLOCK_ERASE_TIME_US = 40000;
  localparam int unsigned SFE_SECTOR_ERASE_TIME_US = 1000000;
  localparam int unsigned SFE_PAGE_ERASE_CYCLES = SFE_PAGE_ERASE_TIME_US * SFE_CLK_MHZ;
  localparam int unsigned SFE_BLOCK_ERASE_CYCLES = SFE_BLOCK_ERASE_TIME_US * SFE_CLK_MHZ;
  localparam int unsigned SFE_SECTOR_ERASE_CYCLES = SFE_SECTOR_ERASE_TIME_US * SFE_CLK_MHZ;
  // host serial clock half period in system cycles (5 MHz link)
  localparam logic [3:0] SFE_SCLK_HALF = 4'h4;
  // how long the host waits to see busy before calling a frame refused
  localparam logic [5:0] SFE_BUSY_WAIT = 6'h20;

  typedef enum logic [1:0] {
    SFE_KIND_PAGE = 2'b00,
    SFE_KIND_BLOCK = 2'b01,
    SFE_KIND_SECTOR = 2'b10
  } sfe_kind_type;
endpackage : sfe_pkg

// ==== testbench/sfe_asserts.sv ====
/*
  Checker for the erase link wires: frame length, serial clock shape and busy length.
  Assumes one host end and one flash end share the watched wires.
*/
`timescale 1ns/1ps
`default_nettype none
module sfe_asserts #(
  parameter int unsigned PAGE_ERASE_CYCLES = 64,
  parameter int unsigned BLOCK_ERASE_CYCLES = 128,
  parameter int unsigned SECTOR_ERASE_CYCLES = 512
) (
  input wire logic sys_clk,
  input wire logic rst,
  input wire logic sclk,
  input wire logic cs_n,
  input wire logic mosi,
  input wire logic ready
);
  // ****************
  // helper counters
  // ****************
  logic [9:0] low_count;
  logic [5:0] rise_count;
  default clocking @(posedge sys_clk); endclocking
  default disable iff (rst);
  // busy cycles so far; ten bits only cover the shortened erase times
  always_ff @(posedge sys_clk) begin
    if (rst || ready) begin
      low_count <= 10'h000;
    end else begin
      low_count <= low_count + 10'h001;
    end
  end
  // clock rises in the current frame, cleared as a frame opens
  always_ff @(posedge sys_clk) begin
    if (rst || $fell(cs_n)) begin
      rise_count <= 6'h00;
    end else if ($rose(sclk)) begin
      rise_count <= rise_count + 6'h01;
    end
  end
  // ****************
  // link properties
  // ****************
  chk_sclk_idle_low: assert property (cs_n |-> !sclk)
    else $error("serial clock high outside a frame");
  chk_mosi_held_high: assert property (sclk && $past(sclk) |-> $stable(mosi))
    else $error("serial data moved while clock high");
  chk_sclk_high_len: assert property ($rose(sclk) |-> sclk [*4] ##1 !sclk)
    else $error("serial clock high phase not four cycles");
  chk_sclk_low_len: assert property ($fell(sclk) |-> !sclk [*4])
    else $error("serial clock low phase too short");
  chk_frame_bits: assert property ($rose(cs_n) |-> rise_count == 6'h20)
    else $error("frame closed without 32 clock rises");
  chk_busy_answer: assert property ($rose(cs_n) |-> ##[1:8] !ready)
    else $error("flash end did not go busy after a frame");
  chk_ready_in_frame: assert property (!cs_n |-> ready)
    else $error("frame sent while flash end busy");
  chk_busy_length: assert property ($rose(ready) |-> low_count == 10'(PAGE_ERASE_CYCLES)
    || low_count == 10'(BLOCK_ERASE_CYCLES) || low_count == 10'(SECTOR_ERASE_CYCLES))
    else $error("busy length matches no erase time");
  cov_page_busy: cover property ($rose(ready) && low_count == 10'(PAGE_ERASE_CYCLES));
  cov_block_busy: cover property ($rose(ready) && low_count == 10'(BLOCK_ERASE_CYCLES));
  cov_sector_busy: cover property ($rose(ready) && low_count == 10'(SECTOR_ERASE_CYCLES));
endmodule : sfe_asserts
`default_nettype wire

// ==== testbench/tb_serial_flash_erase_commands.sv ====
/*
  Testbench: host end driving flash end over one link, plus a raw frame driver on a second flash end.
  Assumes shortened erase times so the whole run stays brief.
*/
`timescale 1ns/1ps
`default_nettype none
module tb_serial_flash_erase_commands
  import sfe_pkg::*;
;
  // ****************
  // set-up
  // ****************
  localparam int unsigned PAGE_CYC = 64;
  localparam int unsigned BLOCK_CYC = 128;
  localparam int unsigned SECTOR_CYC = 512;
  logic sys_clk = 1'b0;
  logic rst = 1'b1;
  logic bin_mode = 1'b0;
  logic erase_fault = 1'b0;
  logic cmd_valid = 1'b0;
  sfe_kind_type cmd_kind = SFE_KIND_PAGE;
  logic [10:0] cmd_page = 11'h000;
  logic [10:0] query_page = 11'h000;
  logic query_erased, ready_busy, err_flag, cmd_ready, cmd_done, cmd_accepted, query_erased2, ready_busy2;
  int failures = 0;
  int cmp_count = 0;
  sfe_link_if link ();
  sfe_link_if link2 ();
  always #12.5 sys_clk = ~sys_clk;
  sfe_host_end sfe_host_end_i (.sys_clk(sys_clk), .rst(rst), .link(link), .binary_page_mode(bin_mode),
    .cmd_valid(cmd_valid), .cmd_kind(cmd_kind), .cmd_page(cmd_page), .cmd_ready(cmd_ready),
    .cmd_done(cmd_done), .cmd_accepted(cmd_accepted));
  sfe_flash_end #(.PAGE_ERASE_CYCLES(PAGE_CYC), .BLOCK_ERASE_CYCLES(BLOCK_CYC), .SECTOR_ERASE_CYCLES(SECTOR_CYC))
    sfe_flash_end_i (.sys_clk(sys_clk), .rst(rst), .link(link), .binary_page_mode(bin_mode),
    .erase_fault(erase_fault), .query_page(query_page), .query_erased(query_erased), .ready_busy(ready_busy),
    .erase_program_error_flag(err_flag));
  // second flash end faces the raw driver, so broken frames can be sent on purpose
  sfe_flash_end #(.PAGE_ERASE_CYCLES(PAGE_CYC), .BLOCK_ERASE_CYCLES(BLOCK_CYC), .SECTOR_ERASE_CYCLES(SECTOR_CYC))
    sfe_flash_end_i2 (.sys_clk(sys_clk), .rst(rst), .link(link2), .binary_page_mode(bin_mode),
    .erase_fault(erase_fault), .query_page(query_page), .query_erased(query_erased2), .ready_busy(ready_busy2),
    .erase_program_error_flag());
  sfe_asserts #(.PAGE_ERASE_CYCLES(PAGE_CYC), .BLOCK_ERASE_CYCLES(BLOCK_CYC), .SECTOR_ERASE_CYCLES(SECTOR_CYC))
    sfe_asserts_i (.sys_clk(sys_clk), .rst(rst), .sclk(link.sclk), .cs_n(link.cs_n), .mosi(link.mosi),
    .ready(link.ready));
  // ****************
  // tasks
  // ****************
  task automatic compare(input logic got, input logic exp, input string what);
    cmp_count++;
    if (got !== exp) begin
      failures++;
      $display("wrong value at %0t: %s", $time, what);
    end
  endtask : compare
  task automatic report_and_stop;
    $display("comparisons %0d mismatches %0d", cmp_count, failures);
    if (failures == 0 && cmp_count > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask : report_and_stop
  // one whole host command; waits are bounded, the watchdog catches a hang
  task automatic run_cmd(input sfe_kind_type k, input logic [10:0] p, input logic f);
    int n;
    n = 0;
    while (cmd_ready !== 1'b1 && n < 400) begin
      @(posedge sys_clk);
      #1;
      n++;
    end
    compare(cmd_ready, 1'b1, "host end never ready");
    @(posedge sys_clk);
    erase_fault <= f;
    cmd_kind <= k;
    cmd_page <= p;
    cmd_valid <= 1'b1;
    @(posedge sys_clk);
    cmd_valid <= 1'b0;
    n = 0;
    do begin
      @(posedge sys_clk);
      #1;
      n++;
    end while (cmd_done !== 1'b1 && n < 1200);
    compare(cmd_done, 1'b1, "command never finished");
    compare(cmd_accepted, 1'b1, "command not accepted");
    compare(ready_busy, 1'b1, "not ready after erase");
    compare(err_flag, f, "erase error flag");
  endtask : run_cmd
  task automatic check_page(input logic [10:0] p, input logic exp, input logic far);
    @(posedge sys_clk);
    query_page <= p;
    repeat (2) @(posedge sys_clk);
    #1;
    compare(far ? query_erased2 : query_erased, exp, "page erased state");
  endtask : check_page
  // raw frame: adj of -1 or +1 sends one bit short or one bit long
  task automatic send_frame(input logic [31:0] fr, input int adj);
    @(posedge sys_clk);
    link2.cs_n <= 1'b0;
    for (int i = 0; i < 32 + adj; i++) begin
      link2.mosi <= (i < 32) ? fr[31 - i] : ~fr[0];
      repeat (4) @(posedge sys_clk);
      link2.sclk <= 1'b1;
      repeat (4) @(posedge sys_clk);
      link2.sclk <= 1'b0;
    end
    repeat (4) @(posedge sys_clk);
    link2.cs_n <= 1'b1;
    link2.mosi <= ~link2.mosi;
  endtask : send_frame
  task automatic watch_busy(input logic exp);
    logic seen;
    seen = 1'b0;
    for (int n = 0; n < 16; n++) begin
      @(posedge sys_clk);
      #1;
      if (link2.ready === 1'b0) seen = 1'b1;
    end
    compare(seen, exp, "busy after raw frame");
    repeat (80) @(posedge sys_clk);
    #1;
    compare(ready_busy2, 1'b1, "not ready after raw frame");
  endtask : watch_busy
  // ****************
  // scenarios
  // ****************
  task automatic t_fault;
    run_cmd(SFE_KIND_SECTOR, 11'h00D, 1'b1);
    run_cmd(SFE_KIND_SECTOR, 11'h2A7, 1'b1);
    check_page(11'h008, 1'b0, 1'b0);
    check_page(11'h0FF, 1'b0, 1'b0);
    check_page(11'h200, 1'b0, 1'b0);
    $display("test fault done");
  endtask : t_fault
  task automatic t_page;
    run_cmd(SFE_KIND_PAGE, 11'h013, 1'b0);
    check_page(11'h013, 1'b1, 1'b0);
    check_page(11'h012, 1'b0, 1'b0);
    check_page(11'h014, 1'b0, 1'b0);
    bin_mode <= 1'b1;
    run_cmd(SFE_KIND_PAGE, 11'h020, 1'b0);
    check_page(11'h020, 1'b1, 1'b0);
    check_page(11'h021, 1'b0, 1'b0);
    bin_mode <= 1'b0;
    $display("test page done");
  endtask : t_page
  task automatic t_block;
    run_cmd(SFE_KIND_BLOCK, 11'h02D, 1'b0);
    check_page(11'h028, 1'b1, 1'b0);
    check_page(11'h02F, 1'b1, 1'b0);
    check_page(11'h027, 1'b0, 1'b0);
    check_page(11'h030, 1'b0, 1'b0);
    bin_mode <= 1'b1;
    run_cmd(SFE_KIND_BLOCK, 11'h03B, 1'b0);
    check_page(11'h038, 1'b1, 1'b0);
    check_page(11'h040, 1'b0, 1'b0);
    $display("test block done");
  endtask : t_block
  task automatic t_sector;
    run_cmd(SFE_KIND_SECTOR, 11'h3C5, 1'b0);
    check_page(11'h300, 1'b1, 1'b0);
    check_page(11'h3FF, 1'b1, 1'b0);
    check_page(11'h2FF, 1'b0, 1'b0);
    bin_mode <= 1'b0;
    run_cmd(SFE_KIND_SECTOR, 11'h005, 1'b0);
    check_page(11'h000, 1'b1, 1'b0);
    check_page(11'h007, 1'b1, 1'b0);
    check_page(11'h008, 1'b0, 1'b0);
    $display("test sector done");
  endtask : t_sector
  task automatic t_refused;
    logic [31:0] fr;
    fr = {SFE_OP_PAGE_ERASE, 4'h0, 11'h123, 9'h000};
    send_frame(fr, -1);
    watch_busy(1'b0);
    send_frame(fr, 1);
    watch_busy(1'b0);
    send_frame({8'h18, fr[23:0]}, 0);
    watch_busy(1'b0);
    send_frame(fr, 0);
    watch_busy(1'b1);
    check_page(11'h123, 1'b1, 1'b1);
    $display("test refused done");
  endtask : t_refused
  // ****************
  // main sequence and watchdog
  // ****************
  initial begin
    link2.sclk <= 1'b0;
    link2.cs_n <= 1'b1;
    link2.mosi <= 1'b0;
    repeat (12) @(posedge sys_clk);
    rst <= 1'b0;
    t_fault;
    t_page;
    t_block;
    t_sector;
    t_refused;
    report_and_stop;
  end
  // span is about five times the expected run
  initial begin
    repeat (30000) @(posedge sys_clk);
    failures++;
    $display("wrong value at %0t: watchdog expired", $time);
    report_and_stop;
  end
endmodule : tb_serial_flash_erase_commands
`default_nettype wire
